/* src/flash_program_data_controller.sv */
`timescale 1ns/1ns
`include "flash_ctrl_consts.svh"
module flash_program_data_controller import flash_ctrl_pkg::*; #(
  parameter int PTR_W = 14,
  parameter int LATCH_AW = 7
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  // Flash array side
  output logic ARR_REQ,
  output arr_req_t ARR_CMD,
  input wire logic ARR_ACK,
  input wire logic [7:0] ARR_RDATA,
  // Status
  output logic BUSY,
  // Boot, code mapping and flash sleep
  input wire logic SOFT_RST,
  input wire logic [15:0] CODE_ADDR,
  output logic CODE_SEL_XRAM,
  output logic RUN_FROM_XRAM,
  output logic FLASH_SLEEP_EN
);
  // Register state
  logic [2:0] cmd_r; // Command field
  logic info_en_r; // Information area access enable
  logic [7:0] data_port_r; // Data port byte
  logic zone_open_r, prog_open_r, data_open_r; // Unlock flags
  logic [6:0] partition_r; // Partition value
  logic part_b7_r; // Plain storage bit 7
  logic [PTR_W-1:0] ptr_r; // Address pointer
  logic boot_r, sleep_r; // Memory control bits
  logic run_xram_r; // Running from external RAM
  seq_state_t state_r;
  logic go_r; // One-cycle start of write or erase
  logic fetch_pend_r; // Read prefetch wanted
  logic [LATCH_AW-1:0] idx_r; // Latch walk counter
  logic lat_we;
  logic [LATCH_AW-1:0] lat_waddr, lat_raddr;
  logic [7:0] lat_wdata, lat_rdata;
  // Bus decode
  logic wr_cmd, wr_dat, wr_lock, wr_part, wr_ptl, wr_pth, wr_mem, rd_dat, rd_mode;
  assign wr_cmd = WR && ADDR == `FLASH_COMMAND_ADDR;
  assign wr_dat = WR && ADDR == `FLASH_DATA_PORT_ADDR;
  assign wr_lock = WR && ADDR == `FLASH_LOCK_KEY_ADDR;
  assign wr_part = WR && ADDR == `AREA_PARTITION_ADDR;
  assign wr_ptl = WR && ADDR == `ADDR_POINTER_LOW_ADDR;
  assign wr_pth = WR && ADDR == `ADDR_POINTER_HIGH_ADDR;
  assign wr_mem = WR && ADDR == `MEMORY_CONTROL_ADDR;
  assign rd_dat = RD && ADDR == `FLASH_DATA_PORT_ADDR;
  assign rd_mode = cmd_r == CMD_DATA_RD || cmd_r == CMD_PROG_RD;

  // Data-area commands are logical, offset by the partition base
  function automatic logic [15:0] phys_addr(input logic [2:0] c, input logic [PTR_W-1:0] p,
                                            input logic [6:0] n);
    logic [15:0] base;
    base = 16'({n, 9'h000});
    if (c == CMD_DATA_RD || c == CMD_DATA_WR || c == CMD_DATA_ER) begin
      phys_addr = 16'(p) + base;
    end else begin
      phys_addr = 16'(p);
    end
  endfunction

  // Whether the target area of a write or erase is open
  function automatic logic area_open(input logic [2:0] c, input logic z, input logic pr,
                                     input logic d, input logic [6:0] n);
    unique case (c)
      CMD_DATA_WR, CMD_DATA_ER: area_open = d || z;
      CMD_PROG_WR, CMD_PROG_ER: area_open = (pr || z) && n != 7'h00;
      CMD_SECT_ER: area_open = z;
      default: area_open = 1'b0;
    endcase
  endfunction

  // Command field: held for reads and writes, cleared after erase
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_r <= 3'h0;
      info_en_r <= 1'b0;
    end else if (wr_cmd) begin
      cmd_r <= WDATA[2:0];
      info_en_r <= WDATA[`CMD_INFO_EN_BIT];
    end else if (state_r == ST_ERASE && ARR_ACK) begin
      cmd_r <= 3'h0;
    end else if (go_r && state_r == ST_IDLE && !area_open(cmd_r, zone_open_r, prog_open_r,
                                                      data_open_r, partition_r) &&
                 (cmd_r == CMD_DATA_ER || cmd_r == CMD_PROG_ER || cmd_r == CMD_SECT_ER)) begin
      cmd_r <= 3'h0;
    end
  end

  // Start pulse for write and erase commands
  always_ff @(posedge CLK) begin
    if (RST) begin
      go_r <= 1'b0;
    end else begin
      go_r <= wr_cmd && (WDATA[1:0] == 2'b10 || WDATA[1:0] == 2'b11 || WDATA[2:0] == 3'h4);
    end
  end

  // Unlock flags: keys open, relock closes everything
  always_ff @(posedge CLK) begin
    if (RST) begin
      zone_open_r <= 1'b0;
      prog_open_r <= 1'b0;
      data_open_r <= 1'b0;
    end else if (wr_lock) begin
      if (WDATA == `KEY_RELOCK) begin
        zone_open_r <= 1'b0;
        prog_open_r <= 1'b0;
        data_open_r <= 1'b0;
      end else begin
        zone_open_r <= zone_open_r || WDATA == `KEY_ZONE;
        prog_open_r <= prog_open_r || WDATA == `KEY_PROG;
        data_open_r <= data_open_r || WDATA == `KEY_DATA;
      end
    end
  end

  // Partition register; values above the limit are software's problem
  always_ff @(posedge CLK) begin
    if (RST) begin
      {part_b7_r, partition_r} <= `PARTITION_RST;
    end else if (wr_part) begin
      {part_b7_r, partition_r} <= WDATA;
    end
  end

  // Pointer: loaded by software, bumped by every data port write and by data port reads in a read mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      ptr_r <= `POINTER_RST;
    end else if (wr_ptl) begin
      ptr_r[7:0] <= WDATA;
    end else if (wr_pth) begin
      ptr_r[PTR_W-1:8] <= WDATA[PTR_W-9:0];
    end else if (wr_dat || (rd_dat && rd_mode)) begin
      ptr_r <= ptr_r + 1'b1;
    end
  end

  // Data port: software byte, or prefetched flash byte
  always_ff @(posedge CLK) begin
    if (RST) begin
      data_port_r <= `DATA_PORT_RST;
    end else if (wr_dat) begin
      data_port_r <= WDATA;
    end else if (state_r == ST_READ && ARR_ACK) begin
      data_port_r <= ARR_RDATA;
    end
  end

  // Prefetch request: set wins over the clear at sequencer start
  always_ff @(posedge CLK) begin
    if (RST) begin
      fetch_pend_r <= 1'b0;
    end else if ((wr_cmd && (WDATA[2:0] == 3'h1 || WDATA[2:0] == 3'h5)) ||
                 (rd_mode && (wr_ptl || wr_pth || rd_dat))) begin
      fetch_pend_r <= 1'b1;
    end else if (state_r == ST_IDLE && !go_r) begin
      fetch_pend_r <= 1'b0;
    end
  end

  // Memory control and run location
  always_ff @(posedge CLK) begin
    if (RST) begin
      boot_r <= 1'b0;
      sleep_r <= 1'b0;
      run_xram_r <= 1'b0;
    end else begin
      if (wr_mem) begin
        boot_r <= WDATA[`MEMCTL_BOOT_BIT];
        sleep_r <= WDATA[`MEMCTL_SLEEP_BIT];
      end
      if (SOFT_RST) begin
        run_xram_r <= boot_r;
      end
    end
  end

  // Code fetch steering into the mapped RAM window
  always_ff @(posedge CLK) begin
    if (RST) begin
      CODE_SEL_XRAM <= 1'b0;
    end else begin
      CODE_SEL_XRAM <= run_xram_r && CODE_ADDR <= `XRAM_CODE_TOP;
    end
  end
  assign RUN_FROM_XRAM = run_xram_r;
  assign FLASH_SLEEP_EN = sleep_r;

  // Sequencer: prefetch, page program, erase, latch clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      idx_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          idx_r <= '0;
          if (wr_cmd && WDATA[`CMD_LATCH_CLR_BIT]) begin
            state_r <= ST_CLEAR;
          end else if (go_r && area_open(cmd_r, zone_open_r, prog_open_r, data_open_r,
                                         partition_r)) begin
            if (cmd_r == CMD_DATA_WR || cmd_r == CMD_PROG_WR) begin
              state_r <= ST_PG_FETCH;
            end else begin
              state_r <= ST_ERASE;
            end
          end else if (fetch_pend_r && rd_mode) begin
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (ARR_ACK) begin
            state_r <= ST_IDLE;
          end
        end
        ST_PG_FETCH: state_r <= ST_PG_WRITE;
        ST_PG_WRITE: begin
          if (ARR_ACK) begin
            idx_r <= idx_r + 1'b1;
            state_r <= (idx_r == LATCH_AW'(`LATCH_BYTES - 1)) ? ST_IDLE : ST_PG_FETCH;
          end
        end
        ST_ERASE: begin
          if (ARR_ACK) begin
            state_r <= ST_IDLE;
          end
        end
        ST_CLEAR: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r == LATCH_AW'(`LATCH_BYTES - 1)) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Latch ports: clear walk, else data port writes
  always_comb begin
    lat_we = wr_dat || state_r == ST_CLEAR;
    lat_waddr = (state_r == ST_CLEAR) ? idx_r : ptr_r[LATCH_AW-1:0];
    lat_wdata = (state_r == ST_CLEAR) ? `LATCH_FILL : WDATA;
    lat_raddr = idx_r;
  end

  page_latch_mem #(.DEPTH(`LATCH_BYTES), .AW(LATCH_AW)) u_latch (
    .clk(CLK),
    .we(lat_we),
    .waddr(lat_waddr),
    .wdata(lat_wdata),
    .raddr(lat_raddr),
    .rdata(lat_rdata)
  );

  // Array request: raised on entering the read, page write or erase state, dropped on acknowledge
  always_ff @(posedge CLK) begin
    if (RST) begin
      ARR_REQ <= 1'b0;
      ARR_CMD <= '{op: ARR_IDLE, info: 1'b0, addr: 16'h0000, wdata: 8'h00};
    end else if (ARR_REQ) begin
      if (ARR_ACK) begin
        ARR_REQ <= 1'b0;
      end
    end else if (state_r == ST_READ) begin
      ARR_REQ <= 1'b1;
      ARR_CMD <= '{op: ARR_READ, info: info_en_r,
                   addr: phys_addr(cmd_r, ptr_r, partition_r), wdata: 8'h00};
    end else if (state_r == ST_PG_WRITE) begin
      ARR_REQ <= 1'b1;
      ARR_CMD <= '{op: ARR_WRITE, info: info_en_r, wdata: lat_rdata,
                   addr: phys_addr(cmd_r, {ptr_r[PTR_W-1:LATCH_AW], idx_r}, partition_r)};
    end else if (state_r == ST_ERASE) begin
      ARR_REQ <= 1'b1;
      ARR_CMD <= '{op: (cmd_r == CMD_SECT_ER) ? ARR_SECTOR_ERASE : ARR_PAGE_ERASE,
                   info: info_en_r, addr: phys_addr(cmd_r, ptr_r, partition_r), wdata: 8'h00};
    end
  end

  // Busy flag
  always_ff @(posedge CLK) begin
    if (RST) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= state_r != ST_IDLE || go_r;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        `MEMORY_CONTROL_ADDR: RDATA <= {1'b0, sleep_r, 5'h00, boot_r};
        `FLASH_COMMAND_ADDR: RDATA <= {info_en_r, 4'h0, cmd_r};
        `FLASH_DATA_PORT_ADDR: RDATA <= data_port_r;
        `FLASH_LOCK_KEY_ADDR: RDATA <= {4'h0, zone_open_r, prog_open_r, data_open_r, 1'b0};
        `AREA_PARTITION_ADDR: RDATA <= {part_b7_r, partition_r};
        `ADDR_POINTER_LOW_ADDR: RDATA <= ptr_r[7:0];
        `ADDR_POINTER_HIGH_ADDR: RDATA <= 8'(ptr_r[PTR_W-1:8]);
        default: RDATA <= 8'h00;
      endcase
    end
  end

  // Checks
  AST_RELOCK: assert property (@(posedge CLK) disable iff (RST)
    wr_lock && WDATA == `KEY_RELOCK |=> !zone_open_r && !prog_open_r && !data_open_r)
    else $error("relock left an area open");
  AST_LOCKED_NO_WRITE: assert property (@(posedge CLK) disable iff (RST)
    ARR_REQ && ARR_CMD.op == ARR_WRITE |-> zone_open_r || prog_open_r || data_open_r)
    else $error("write issued while locked");
  AST_ERASE_CLEARS: assert property (@(posedge CLK) disable iff (RST)
    state_r == ST_ERASE && ARR_ACK && !wr_cmd |=> cmd_r == 3'h0)
    else $error("erase did not clear command");
  AST_PTR_STEP: assert property (@(posedge CLK) disable iff (RST)
    wr_dat && !wr_ptl && !wr_pth |=> ptr_r == $past(ptr_r) + 1'b1)
    else $error("pointer did not advance");
  AST_CLEAR_LEN: assert property (@(posedge CLK) disable iff (RST)
    state_r == ST_IDLE && wr_cmd && WDATA[3] |=> state_r == ST_CLEAR ##128 state_r == ST_IDLE)
    else $error("latch clear length wrong");
  AST_DATA_BASE: assert property (@(posedge CLK) disable iff (RST)
    ARR_REQ && $rose(ARR_REQ) && cmd_r == CMD_DATA_RD |->
    ARR_CMD.addr == 16'(ptr_r) + 16'({partition_r, 9'h000}))
    else $error("data address lacks base");
  AST_READ_KEEPS: assert property (@(posedge CLK) disable iff (RST)
    rd_mode && !wr_cmd |=> cmd_r == $past(cmd_r))
    else $error("read command changed");
  AST_PROG_ZERO_PART: assert property (@(posedge CLK) disable iff (RST)
    state_r == ST_IDLE && go_r && partition_r == 7'h00 && !zone_open_r &&
    cmd_r == CMD_PROG_WR |=> state_r == ST_IDLE)
    else $error("program write with no program area");
  AST_BOOT: assert property (@(posedge CLK) disable iff (RST)
    SOFT_RST |=> RUN_FROM_XRAM == $past(boot_r))
    else $error("soft reset ignored boot bit");
  COV_PAGE: cover property (@(posedge CLK) state_r == ST_PG_WRITE && ARR_ACK && idx_r == 7'h7F);
  COV_ERASE: cover property (@(posedge CLK) state_r == ST_ERASE && ARR_ACK);
  COV_READ: cover property (@(posedge CLK) rd_dat && rd_mode);
endmodule // flash_program_data_controller

/* src/flash_ctrl_consts.svh */
// Summary of operation
// - Command field codes select read, write, erase
// - Erase completion clears command field automatically
// - Read/write commands persist; data port drives them
// - Command bit 3 clears page write latch
// - Keys 28H/29H/2AH unlock zone/program/data
// - Key AAH relocks; writes and erases refused
// - Lock read shows unlock flags bits 3..1
// - Partition N: program below N*512, data above
// - Partition zero makes whole flash data
// - Data port write fills latch at pointer low
// - Each data port write advances pointer
// - Read command: each read returns byte, advances
// - Programming is whole 128-byte pages only
// - Data commands add partition base to pointer
// - External RAM mapped as code at 0000H-07FFH
// - Boot bit one: soft reset runs RAM
// - Boot select is memory control bit 0
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH
// Register addresses
`define MEMORY_CONTROL_ADDR 16'hFC00
`define FLASH_COMMAND_ADDR 16'hFC01
`define FLASH_DATA_PORT_ADDR 16'hFC02
`define FLASH_LOCK_KEY_ADDR 16'hFC03
`define AREA_PARTITION_ADDR 16'hFC04
`define ADDR_POINTER_LOW_ADDR 16'hFC05
`define ADDR_POINTER_HIGH_ADDR 16'hFC06
// Field positions
`define CMD_INFO_EN_BIT 7
`define CMD_LATCH_CLR_BIT 3
`define MEMCTL_SLEEP_BIT 6
`define MEMCTL_BOOT_BIT 0
`define LOCK_ZONE_BIT 3
`define LOCK_PROG_BIT 2
`define LOCK_DATA_BIT 1
// Lock keys
`define KEY_ZONE 8'h28
`define KEY_PROG 8'h29
`define KEY_DATA 8'h2A
`define KEY_RELOCK 8'hAA
// Reset values
`define DATA_PORT_RST 8'h00
`define PARTITION_RST 8'h80
`define POINTER_RST 14'h0000
// Partition unit is 512 bytes, i.e. a shift of 9
`define PART_SHIFT 9
// Latch geometry and cleared value
`define LATCH_BYTES 128
`define LATCH_FILL 8'hFF
// Mapped external RAM code window top, 0000H..07FFH
`define XRAM_CODE_TOP 16'h07FF
`endif

/* src/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;
  // Command field encodings
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_DATA_RD = 3'h1, CMD_DATA_WR = 3'h2, CMD_DATA_ER = 3'h3,
    CMD_SECT_ER = 3'h4, CMD_PROG_RD = 3'h5, CMD_PROG_WR = 3'h6, CMD_PROG_ER = 3'h7
  } flash_cmd_t;
  // Operation requested of the flash array
  typedef enum logic [2:0] {
    ARR_READ, ARR_WRITE, ARR_PAGE_ERASE, ARR_SECTOR_ERASE, ARR_IDLE
  } arr_op_t;
  // One array request, held with its strobe
  typedef struct packed {
    arr_op_t op;
    logic info;
    logic [15:0] addr;
    logic [7:0] wdata;
  } arr_req_t;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_PG_FETCH, ST_PG_WRITE, ST_ERASE, ST_CLEAR
  } seq_state_t;
endpackage

/* src/page_latch_mem.sv */
`timescale 1ns/1ns
module page_latch_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port, data one cycle after address
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  // Storage, no reset: cleared explicitly by the sequencer
  logic [7:0] mem [DEPTH];

  // Write side
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule // page_latch_mem

/* verification/flash_array_model.sv */
`timescale 1ns/1ns
module flash_array_model import flash_ctrl_pkg::*; #(
  parameter int SECTOR_BYTES = 512
) (
  // Clock, reset and pace
  input wire logic CLK,
  input wire logic RST,
  input wire logic SLOW,
  // Request side
  input wire logic ARR_REQ,
  input arr_req_t ARR_CMD,
  // Answer side
  output logic ARR_ACK,
  output logic [7:0] ARR_RDATA
);
  logic [7:0] mem [0:65535]; // Array contents
  int cnt; // Cycles spent on the current request
  int n_sect; // Sector erases served
  // Known start pattern, so every byte is predictable
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i ^ (i >> 8));
  end
  // One request at a time; the ack pulse blocks a second serve
  always @(posedge CLK) begin
    ARR_ACK <= 1'b0;
    ARR_RDATA <= RST ? 8'h00 : ~ARR_RDATA; // Stale data is inverted on every cycle, so it matches the last read byte only in alternate cycles
    if (RST) begin
      cnt <= 0;
      n_sect <= 0;
    end else if (ARR_REQ && !ARR_ACK) begin
      if (cnt < (SLOW ? 5 : 0)) begin // Slow answers stall the sequencer
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        ARR_ACK <= 1'b1;
        case (ARR_CMD.op)
          ARR_READ: ARR_RDATA <= mem[ARR_CMD.addr];
          ARR_WRITE: mem[ARR_CMD.addr] <= ARR_CMD.wdata;
          ARR_PAGE_ERASE: begin
            for (int i = 0; i < 128; i++)
              mem[{ARR_CMD.addr[15:7], 7'(i)}] <= 8'hFF;
          end
          ARR_SECTOR_ERASE: begin
            n_sect <= n_sect + 1;
            for (int i = 0; i < SECTOR_BYTES; i++)
              mem[16'(ARR_CMD.addr / SECTOR_BYTES * SECTOR_BYTES + i)] <= 8'hFF;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // flash_array_model

/* verification/flash_program_data_controller_tb_top.sv */
`timescale 1ns/1ns
module flash_program_data_controller_tb_top import flash_ctrl_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic arr_req;
  arr_req_t arr_cmd;
  logic arr_ack;
  logic [7:0] arr_rdata;
  logic busy;
  logic soft_rst = 1'b0;
  logic [15:0] code_addr = 16'h0000;
  logic code_sel_xram;
  logic run_from_xram;
  logic flash_sleep_en;
  logic slow = 1'b0; // Array pace
  int n_fail = 0;
  int checks = 0;
  logic [31:0] seed = 32'd74042;
  logic [7:0] shadow [0:65535]; // Expected array contents
  logic [7:0] lat [0:127]; // Bytes sent to the latch
  logic [7:0] v;
  logic [1:0] pg;
  logic [7:0] keys [4] = '{8'h2A, 8'h29, 8'hAA, 8'h28};
  logic [7:0] lexp [4] = '{8'h02, 8'h06, 8'h00, 8'h08};
  logic [7:0] lmask [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h08};

  always #5 clk = ~clk;

  flash_program_data_controller i_dut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata),
    .ARR_REQ(arr_req), .ARR_CMD(arr_cmd), .ARR_ACK(arr_ack), .ARR_RDATA(arr_rdata),
    .BUSY(busy), .SOFT_RST(soft_rst), .CODE_ADDR(code_addr), .CODE_SEL_XRAM(code_sel_xram),
    .RUN_FROM_XRAM(run_from_xram), .FLASH_SLEEP_EN(flash_sleep_en)
  );
  flash_array_model i_model (
    .CLK(clk), .RST(rst), .SLOW(slow), .ARR_REQ(arr_req), .ARR_CMD(arr_cmd),
    .ARR_ACK(arr_ack), .ARR_RDATA(arr_rdata)
  );

  // Next value of the stimulus sequence
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Verdict and end of run
  task automatic final_report();
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Byte comparison
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register write, strobe held for exactly one edge
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One register read; data lands the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Busy rises one to two cycles after the start (two for a read prefetch), so look only after that
  task automatic wait_idle();
    int i;
    repeat (3) @(posedge clk);
    #1;
    for (i = 0; i < 4000 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 4000) begin
      n_fail++;
      final_report();
    end
  endtask

  // Pointer load, high byte first
  task automatic set_ptr(input logic [13:0] p);
    reg_wr(16'hFC06, {2'b00, p[13:8]});
    reg_wr(16'hFC05, p[7:0]);
  endtask

  // Whole-page program; ok says whether the area is open
  task automatic prog(input logic [2:0] cmd, input logic [7:0] key, input logic [6:0] page,
                      input logic ok, input int base);
    reg_wr(16'hFC01, 8'h00);
    reg_wr(16'hFC03, key);
    set_ptr(14'h0000);
    reg_wr(16'hFC01, 8'h08);
    wait_idle();
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      lat[i] = seed[7:0];
      reg_wr(16'hFC02, lat[i]);
    end
    slow <= seed[9];
    reg_rd(16'hFC05, v);
    chk("pointer", 8'h80, v);
    set_ptr({page, 7'h00});
    reg_wr(16'hFC01, {5'h00, cmd});
    wait_idle();
    reg_rd(16'hFC01, v);
    chk("command", {5'h00, cmd}, v);
    reg_wr(16'hFC03, 8'hAA);
    for (int i = 0; i < 128 && ok; i++)
      shadow[base + page * 128 + i] = lat[i];
  endtask

  // Page or sector erase; the command field must clear itself
  task automatic erase(input logic [2:0] cmd, input logic [7:0] key, input logic [6:0] page,
                       input logic ok, input int base);
    reg_wr(16'hFC01, 8'h00);
    reg_wr(16'hFC03, key);
    reg_wr(16'hFC01, 8'h08);
    wait_idle();
    set_ptr({page, 7'h00});
    reg_wr(16'hFC01, {5'h00, cmd});
    wait_idle();
    reg_rd(16'hFC01, v);
    chk("command", 8'h00, v);
    reg_wr(16'hFC03, 8'hAA);
    for (int i = 0; i < ((cmd == 3'h4) ? 512 : 128) && ok; i++)
      shadow[base + page * 128 + i] = 8'hFF;
  endtask

  // Streamed read through the data port
  task automatic rdback(input logic [2:0] cmd, input logic [13:0] p, input int n, input int base);
    reg_wr(16'hFC01, 8'h00);
    set_ptr(p);
    reg_wr(16'hFC01, {5'h00, cmd});
    wait_idle();
    for (int i = 0; i < n; i++) begin
      reg_rd(16'hFC02, v);
      chk("data", shadow[base + p + i], v);
      wait_idle();
    end
    reg_wr(16'hFC01, 8'h00);
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 65536; i++)
      shadow[i] = 8'(i ^ (i >> 8));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped address last
    for (int i = 0; i < 8; i++) begin
      reg_rd(16'hFC00 + 16'(i), v);
      chk("reset", (i == 4) ? 8'h80 : 8'h00, v);
    end
    // Keys and the open flags they raise
    foreach (keys[i]) begin
      reg_wr(16'hFC03, keys[i]);
      reg_rd(16'hFC03, v);
      chk("lock", lexp[i], v & lmask[i]);
    end
    reg_wr(16'hFC04, 8'h01);
    seed = lfsr(seed);
    pg = seed[1:0];
    prog(3'h2, 8'h2A, {5'h00, pg}, 1'b1, 512);
    rdback(3'h1, 14'({pg, 7'h00}) + 14'd120, 16, 512);
    prog(3'h6, 8'h29, 7'h00, 1'b1, 0);
    rdback(3'h5, 14'h0000, 4, 0);
    erase(3'h3, 8'h2A, {5'h00, pg}, 1'b1, 512);
    rdback(3'h1, 14'({pg, 7'h00}), 4, 512);
    reg_wr(16'hFC04, 8'h00);
    rdback(3'h1, 14'h0000, 4, 0);
    reg_wr(16'hFC04, 8'h01);
    erase(3'h7, 8'h29, 7'h00, 1'b1, 0);
    rdback(3'h5, 14'h0000, 2, 0);
    // Information area read: enable held for the whole access
    set_ptr(14'h0002);
    reg_wr(16'hFC01, 8'h81);
    wait_idle();
    chk("info", 8'h01, {7'h00, arr_cmd.info});
    reg_rd(16'hFC02, v);
    chk("info data", shadow[514], v);
    wait_idle();
    reg_rd(16'hFC01, v);
    chk("command", 8'h81, v);
    reg_wr(16'hFC01, 8'h00);
    // No program area at partition zero, so program writes are refused
    reg_wr(16'hFC04, 8'h00);
    prog(3'h6, 8'h29, 7'h01, 1'b0, 0);
    rdback(3'h5, 14'h0080, 2, 0);
    reg_wr(16'hFC04, 8'h01);
    // Relocked: nothing may reach the array; then a sector erase opened by the zone key
    prog(3'h2, 8'hAA, {5'h00, pg}, 1'b0, 512);
    erase(3'h3, 8'hAA, 7'h01, 1'b0, 512);
    rdback(3'h1, 14'({pg, 7'h00}), 4, 512);
    rdback(3'h1, 14'h0080, 2, 512);
    erase(3'h4, 8'h28, 7'h00, 1'b1, 0);
    chk("sectors", 8'h01, 8'(i_model.n_sect));
    rdback(3'h5, 14'h0100, 2, 0);
    // Boot bit only acts at a soft reset
    reg_wr(16'hFC00, 8'h41);
    @(posedge clk);
    #1;
    chk("sleep", 8'h01, {7'h00, flash_sleep_en});
    chk("boot", 8'h00, {7'h00, run_from_xram});
    @(posedge clk);
    soft_rst <= 1'b1;
    code_addr <= 16'h07FF;
    @(posedge clk);
    soft_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("boot", 8'h01, {7'h00, run_from_xram});
    chk("ram map", 8'h01, {7'h00, code_sel_xram});
    @(posedge clk);
    code_addr <= 16'h0800;
    @(posedge clk);
    #1;
    chk("ram map", 8'h00, {7'h00, code_sel_xram});
    final_report();
  end
endmodule // flash_program_data_controller_tb_top
